// file: include/irc_pkg.sv
// shared constants and types for the integration run controller
package irc_pkg;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] IRC_OFS_CTRL      = 8'h00;
   localparam logic [7:0] IRC_OFS_CMD       = 8'h04;
   localparam logic [7:0] IRC_OFS_TIMER     = 8'h08;
   localparam logic [7:0] IRC_OFS_RS_DATE   = 8'h0c;
   localparam logic [7:0] IRC_OFS_RS_TIME   = 8'h10;
   localparam logic [7:0] IRC_OFS_RE_DATE   = 8'h14;
   localparam logic [7:0] IRC_OFS_RE_TIME   = 8'h18;
   localparam logic [7:0] IRC_OFS_STATUS    = 8'h1c;
   localparam logic [7:0] IRC_OFS_ELAPSED   = 8'h20;
   localparam logic [7:0] IRC_OFS_VALUE     = 8'h24;
   localparam logic [7:0] IRC_OFS_DISP_ELAP = 8'h28;
   localparam logic [7:0] IRC_OFS_DISP_VAL  = 8'h2c;

   // command bit positions (cmd register and key vector)
   localparam int IRC_CMD_START  = 0;
   localparam int IRC_CMD_STOP   = 1;
   localparam int IRC_CMD_RESET  = 2;
   localparam int IRC_CMD_HOLD   = 3;
   localparam int IRC_CMD_SINGLE = 4;
   localparam int IRC_NCMD       = 5;

   // timer field positions: hours [29:16], minutes [13:8], seconds [5:0]
   localparam int IRC_TM_H_LSB = 16;
   localparam int IRC_TM_M_LSB = 8;
   localparam int IRC_TM_S_LSB = 0;
   // date fields: year [31:16], month [11:8], day [4:0]
   localparam int IRC_DT_Y_LSB = 16;
   localparam int IRC_DT_MO_LSB = 8;
   localparam int IRC_DT_D_LSB = 0;

   // limits
   localparam logic [13:0] IRC_TIMER_MAX_H = 14'h2710;           // 10000 hours
   localparam logic [25:0] IRC_MAX_SEC     = 26'h2255100;        // 10000 h in seconds
   localparam logic [11:0] IRC_SEC_PER_H   = 12'he10;            // 3600
   localparam logic [5:0]  IRC_SEC_PER_M   = 6'h3c;              // 60
   localparam logic [5:0]  IRC_FIELD_MAX   = 6'h3b;              // 59
   localparam logic signed [31:0] IRC_VAL_MAX = 32'sh000f423f;   // +999999
   localparam logic signed [31:0] IRC_VAL_MIN = -32'sh000f423f;  // -999999

   // reset values
   localparam logic [2:0]  IRC_CTRL_RST  = 3'h0;
   localparam logic [31:0] IRC_ZERO32    = 32'h0;

   // integration modes
   typedef enum logic [2:0] {
      IRC_M_NORMAL = 3'b000,
      IRC_M_CONT   = 3'b001,
      IRC_M_RNORM  = 3'b010,
      IRC_M_RCONT  = 3'b011
   } irc_mode_t;

   // run states
   typedef enum logic [1:0] {
      IRC_S_RESET = 2'b00,
      IRC_S_READY = 2'b01,
      IRC_S_RUN   = 2'b10,
      IRC_S_STOP  = 2'b11
   } irc_state_t;

   // calendar stamp
   typedef struct packed {
      logic [15:0] year;
      logic [3:0]  month;
      logic [4:0]  day;
      logic [4:0]  hour;
      logic [5:0]  minute;
      logic [5:0]  second;
   } irc_cal_t;

endpackage

// file: logic/irc_top.sv
// integration run controller: start/stop/reset/hold sequencing with wishbone registers
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
module irc_top
   import irc_pkg::*;
(
   // clock and reset
   input  wire  logic               i_ref_clk,
   input  wire  logic               i_nrst,
   // wishbone classic slave
   input  wire  logic               i_wb_cyc,
   input  wire  logic               i_wb_stb,
   input  wire  logic               i_wb_we,
   input  wire  logic [7:0]         i_wb_adr,
   input  wire  logic [3:0]         i_wb_sel,
   input  wire  logic [31:0]        i_wb_dat,
   output       logic [31:0]        o_wb_dat,
   output       logic               o_wb_ack,
   // front panel keys (asynchronous pins)
   input  wire  logic [4:0]         i_keys,
   // system context (same clock domain)
   input  wire  logic               i_meas_normal,
   input  wire  logic               i_sec_tick,
   input  wire  irc_cal_t           i_cal,
   input  wire  logic               i_sample_vld,
   input  wire  logic signed [31:0] i_sample,
   // status and display
   output       logic               o_running,
   output       logic               o_stopped,
   output       logic               o_ready,
   output       logic               o_hold,
   output       logic               o_no_data,
   output       logic [25:0]        o_disp_elapsed,
   output       logic signed [31:0] o_disp_value
);

   // true when stamp a is at or after stamp b
   function automatic logic cal_ge(input irc_cal_t a, input irc_cal_t b);
      cal_ge = (a >= b);
   endfunction

   // true when a timer word lies inside the legal range
   function automatic logic timer_ok(input logic [31:0] w);
      logic [13:0] h;
      logic [5:0]  m;
      logic [5:0]  s;
      h = w[IRC_TM_H_LSB +: 14];
      m = w[IRC_TM_M_LSB +: 6];
      s = w[IRC_TM_S_LSB +: 6];
      if (h == IRC_TIMER_MAX_H) begin
         timer_ok = (m == 6'h00) && (s == 6'h00);
      end else begin
         timer_ok = (h < IRC_TIMER_MAX_H) && (m <= IRC_FIELD_MAX) && (s <= IRC_FIELD_MAX);
      end
   endfunction

   // registers
   irc_state_t         state_q;               // run state
   irc_state_t         state_d;
   logic [2:0]         mode_q;                // selected integration mode
   logic [13:0]        tm_h_q;                // timer hours
   logic [5:0]         tm_m_q;                // timer minutes
   logic [5:0]         tm_s_q;                // timer seconds
   irc_cal_t           rs_q;                  // reserved start stamp
   irc_cal_t           re_q;                  // reserved end stamp
   logic [25:0]        elapsed_q;             // live elapsed seconds
   logic signed [31:0] value_q;               // live integrated value
   logic               sat_q;                 // value hit a display limit
   logic               hold_q;                // display frozen
   logic               no_data_q;             // results cleared
   logic [4:0]         key_s1_q;              // key synchroniser stage one
   logic [4:0]         key_s2_q;              // key synchroniser stage two
   logic [4:0]         key_old_q;             // previous synced keys
   logic               ack_q;                 // bus acknowledge
   logic [31:0]        rdat_q;                // bus read data
   logic               run_q;                 // indicator flops
   logic               stop_q;
   logic               rdy_q;
   logic [25:0]        disp_el_q;             // displayed elapsed
   logic signed [31:0] disp_val_q;            // displayed value

   // combinational helpers
   logic               bus_req;               // new access this cycle
   logic               bus_wr;                // new write this cycle
   logic [4:0]         key_rise;              // key press pulses
   logic [4:0]         cmd;                   // merged command pulses
   logic               cmd_start;
   logic               cmd_stop;
   logic               cmd_reset;
   logic               cfg_open;              // settings writable
   logic [25:0]        timer_sec;             // timer in seconds
   logic               manual;                // normal mode with zero timer
   logic               timed_hit;             // elapsed reaches timer
   logic               max_hit;               // elapsed reaches 10000 h
   logic               end_hit;               // calendar at reserved end
   logic               start_hit;             // calendar at reserved start
   logic               restart;               // repetitive auto reset
   logic signed [32:0] sum;                   // widened accumulate
   logic signed [31:0] value_d;
   logic               sat_d;

   assign bus_req   = i_wb_cyc && i_wb_stb && !ack_q;
   assign bus_wr    = bus_req && i_wb_we;
   assign key_rise  = key_s2_q & ~key_old_q;
   assign cmd       = key_rise | ((bus_wr && (i_wb_adr == IRC_OFS_CMD)) ? i_wb_dat[4:0] : 5'h00);
   // measurement mode gates the three run commands
   assign cmd_start = cmd[IRC_CMD_START] && i_meas_normal;
   assign cmd_stop  = cmd[IRC_CMD_STOP] && i_meas_normal;
   assign cmd_reset = cmd[IRC_CMD_RESET] && i_meas_normal;
   // mode, timer and reservations only change while in reset
   assign cfg_open  = (state_q == IRC_S_RESET);

   // timer seconds from the h:m:s fields
   assign timer_sec = 26'(tm_h_q) * 26'(IRC_SEC_PER_H) + 26'(tm_m_q) * 26'(IRC_SEC_PER_M)
                      + 26'(tm_s_q);
   assign manual    = (mode_q == IRC_M_NORMAL) && (timer_sec == 26'h0);
   // a tick that would carry elapsed onto the timer marks expiry
   assign timed_hit = !manual && (timer_sec != 26'h0) && (elapsed_q + 26'h1 >= timer_sec);
   assign max_hit   = (elapsed_q + 26'h1 >= IRC_MAX_SEC);
   // calendar checks happen on the one second tick only
   assign end_hit   = i_sec_tick && cal_ge(i_cal, re_q);
   assign start_hit = i_sec_tick && cal_ge(i_cal, rs_q);
   // a stop or end stamp on the expiry tick wins, so results are held, not zeroed
   assign restart   = (state_q == IRC_S_RUN) && (state_d == IRC_S_RUN) && i_sec_tick
                      && timed_hit && !sat_q
                      && ((mode_q == IRC_M_CONT) || (mode_q == IRC_M_RCONT));

   // saturating accumulate of incoming samples
   always_comb begin
      sum     = 33'(value_q) + 33'(i_sample);
      value_d = value_q;
      sat_d   = sat_q;
      if (sum >= 33'(IRC_VAL_MAX)) begin
         value_d = IRC_VAL_MAX;
         sat_d   = 1'b1;
      end else if (sum <= 33'(IRC_VAL_MIN)) begin
         value_d = IRC_VAL_MIN;
         sat_d   = 1'b1;
      end else begin
         value_d = sum[31:0];
      end
   end

   // next run state
   always_comb begin
      state_d = state_q;
      case (state_q)
         IRC_S_RESET: begin
            // start only from reset or stopped
            if (cmd_start) begin
               if ((mode_q == IRC_M_RNORM) || (mode_q == IRC_M_RCONT)) begin
                  state_d = IRC_S_READY;
               end else begin
                  state_d = IRC_S_RUN;
               end
            end
         end
         IRC_S_READY: begin
            // waits for the reserved start; stop aborts the wait
            if (cmd_stop) begin
               state_d = IRC_S_STOP;
            end else if (start_hit) begin
               state_d = IRC_S_RUN;
            end
         end
         IRC_S_RUN: begin
            if (cmd_stop) begin
               state_d = IRC_S_STOP;
            end else if (sat_q) begin
               state_d = IRC_S_STOP;
            end else if (i_sec_tick) begin
               case (mode_q)
                  IRC_M_NORMAL: begin
                     if (timed_hit || max_hit) begin
                        state_d = IRC_S_STOP;
                     end
                  end
                  IRC_M_CONT: begin
                     if (max_hit && !timed_hit) begin
                        state_d = IRC_S_STOP;
                     end
                  end
                  IRC_M_RNORM: begin
                     if (end_hit || timed_hit || max_hit) begin
                        state_d = IRC_S_STOP;
                     end
                  end
                  IRC_M_RCONT: begin
                     if (end_hit) begin
                        state_d = IRC_S_STOP;
                     end
                  end
                  default: begin
                     state_d = IRC_S_STOP;
                  end
               endcase
            end
         end
         IRC_S_STOP: begin
            // reset wins over start if both arrive together
            if (cmd_reset) begin
               state_d = IRC_S_RESET;
            end else if (cmd_start) begin
               state_d = IRC_S_RUN;
            end
         end
         default: begin
            state_d = IRC_S_RESET;
         end
      endcase
   end

   // state register and indicator flops follow the next state
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= IRC_S_RESET;
         run_q   <= 1'b0;
         stop_q  <= 1'b0;
         rdy_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         // ready keeps the running lamp on as well
         run_q   <= (state_d == IRC_S_RUN) || (state_d == IRC_S_READY);
         stop_q  <= (state_d == IRC_S_STOP);
         rdy_q   <= (state_d == IRC_S_READY);
      end
   end

   // elapsed time and integrated value
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         elapsed_q <= 26'h0;
         value_q   <= IRC_ZERO32;
         sat_q     <= 1'b0;
      end else if ((state_q == IRC_S_STOP) && cmd_reset) begin
         elapsed_q <= 26'h0;
         value_q   <= IRC_ZERO32;
         sat_q     <= 1'b0;
      end else if (restart) begin
         // a sample landing on the restart edge is dropped
         elapsed_q <= 26'h0;
         value_q   <= IRC_ZERO32;
      end else if ((state_q == IRC_S_RUN) && !sat_q && !cmd_stop) begin
         // the expiring tick still counts, so a timed stop holds the full span
         if (i_sec_tick) begin
            elapsed_q <= elapsed_q + 26'h1;
         end
         if (i_sample_vld) begin
            value_q <= value_d;
            sat_q   <= sat_d;
         end
      end
   end

   // no data flag: set by reset, cleared by the first run
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         no_data_q <= 1'b1;
      end else if ((state_q == IRC_S_STOP) && cmd_reset) begin
         no_data_q <= 1'b1;
      end else if (state_d == IRC_S_RUN) begin
         no_data_q <= 1'b0;
      end
   end

   // hold toggle and display copies
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hold_q     <= 1'b0;
         disp_el_q  <= 26'h0;
         disp_val_q <= IRC_ZERO32;
      end else begin
         if (cmd[IRC_CMD_HOLD]) begin
            hold_q <= !hold_q;
         end
         // while held, only a single command refreshes the display
         if (!hold_q || cmd[IRC_CMD_SINGLE]) begin
            disp_el_q  <= elapsed_q;
            disp_val_q <= value_q;
         end
      end
   end

   // key synchroniser and edge memory
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         key_s1_q  <= 5'h00;
         key_s2_q  <= 5'h00;
         key_old_q <= 5'h00;
      end else begin
         key_s1_q  <= i_keys;
         key_s2_q  <= key_s1_q;
         key_old_q <= key_s2_q;
      end
   end

   // configuration writes, refused outside the reset state
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_q <= IRC_CTRL_RST;
         tm_h_q <= 14'h0;
         tm_m_q <= 6'h00;
         tm_s_q <= 6'h00;
         rs_q   <= '0;
         re_q   <= '0;
      end else if (bus_wr && cfg_open) begin
         if (i_wb_adr == IRC_OFS_CTRL) begin
            if (i_wb_sel[0]) begin
               mode_q <= {1'b0, i_wb_dat[1:0]};
            end
         end else if (i_wb_adr == IRC_OFS_TIMER) begin
            // an out of range timer word is dropped whole
            if (timer_ok(i_wb_dat) && (i_wb_sel == 4'hf)) begin
               tm_h_q <= i_wb_dat[IRC_TM_H_LSB +: 14];
               tm_m_q <= i_wb_dat[IRC_TM_M_LSB +: 6];
               tm_s_q <= i_wb_dat[IRC_TM_S_LSB +: 6];
            end
         end else if (i_wb_adr == IRC_OFS_RS_DATE) begin
            rs_q.year  <= i_wb_dat[IRC_DT_Y_LSB +: 16];
            rs_q.month <= i_wb_dat[IRC_DT_MO_LSB +: 4];
            rs_q.day   <= i_wb_dat[IRC_DT_D_LSB +: 5];
         end else if (i_wb_adr == IRC_OFS_RS_TIME) begin
            rs_q.hour   <= i_wb_dat[IRC_TM_H_LSB +: 5];
            rs_q.minute <= i_wb_dat[IRC_TM_M_LSB +: 6];
            rs_q.second <= i_wb_dat[IRC_TM_S_LSB +: 6];
         end else if (i_wb_adr == IRC_OFS_RE_DATE) begin
            re_q.year  <= i_wb_dat[IRC_DT_Y_LSB +: 16];
            re_q.month <= i_wb_dat[IRC_DT_MO_LSB +: 4];
            re_q.day   <= i_wb_dat[IRC_DT_D_LSB +: 5];
         end else if (i_wb_adr == IRC_OFS_RE_TIME) begin
            re_q.hour   <= i_wb_dat[IRC_TM_H_LSB +: 5];
            re_q.minute <= i_wb_dat[IRC_TM_M_LSB +: 6];
            re_q.second <= i_wb_dat[IRC_TM_S_LSB +: 6];
         end
      end
   end

   // bus acknowledge and registered read data
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ack_q  <= 1'b0;
         rdat_q <= IRC_ZERO32;
      end else begin
         ack_q <= bus_req;
         if (!bus_req) begin
            rdat_q <= IRC_ZERO32;
         end else if (i_wb_adr == IRC_OFS_CTRL) begin
            rdat_q <= {29'h0, mode_q};
         end else if (i_wb_adr == IRC_OFS_TIMER) begin
            rdat_q <= {2'h0, tm_h_q, 2'h0, tm_m_q, 2'h0, tm_s_q};
         end else if (i_wb_adr == IRC_OFS_RS_DATE) begin
            rdat_q <= {rs_q.year, 4'h0, rs_q.month, 3'h0, rs_q.day};
         end else if (i_wb_adr == IRC_OFS_RS_TIME) begin
            rdat_q <= {11'h0, rs_q.hour, 2'h0, rs_q.minute, 2'h0, rs_q.second};
         end else if (i_wb_adr == IRC_OFS_RE_DATE) begin
            rdat_q <= {re_q.year, 4'h0, re_q.month, 3'h0, re_q.day};
         end else if (i_wb_adr == IRC_OFS_RE_TIME) begin
            rdat_q <= {11'h0, re_q.hour, 2'h0, re_q.minute, 2'h0, re_q.second};
         end else if (i_wb_adr == IRC_OFS_STATUS) begin
            rdat_q <= {25'h0, sat_q, no_data_q, hold_q, rdy_q, stop_q, run_q};
         end else if (i_wb_adr == IRC_OFS_ELAPSED) begin
            rdat_q <= {6'h0, elapsed_q};
         end else if (i_wb_adr == IRC_OFS_VALUE) begin
            rdat_q <= value_q;
         end else if (i_wb_adr == IRC_OFS_DISP_ELAP) begin
            rdat_q <= {6'h0, disp_el_q};
         end else if (i_wb_adr == IRC_OFS_DISP_VAL) begin
            rdat_q <= disp_val_q;
         end else begin
            // unmapped and command offsets read zero
            rdat_q <= IRC_ZERO32;
         end
      end
   end

   // outputs straight from flops
   assign o_wb_ack       = ack_q;
   assign o_wb_dat       = rdat_q;
   assign o_running      = run_q;
   assign o_stopped      = stop_q;
   assign o_ready        = rdy_q;
   assign o_hold         = hold_q;
   assign o_no_data      = no_data_q;
   assign o_disp_elapsed = disp_el_q;
   assign o_disp_value   = disp_val_q;

endmodule

// file: testbench/irc_chk.sv
// port checker for the integration run controller
module irc_chk
   import irc_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_nrst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_meas_normal,
   input wire logic        o_running,
   input wire logic        o_ready,
   input wire logic        o_stopped,
   input wire logic        o_hold,
   input wire logic        o_no_data,
   input wire logic [25:0] o_disp_elapsed
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // a request not yet answered
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   // a command write carrying exactly one command bit
   sequence s_cmd(logic [4:0] m);
      s_req ##0 i_wb_we && i_wb_adr == IRC_OFS_CMD && i_wb_dat[4:0] == m;
   endsequence
   property p_ack;
      s_req |=> o_wb_ack ##1 !o_wb_ack;
   endproperty
   property p_excl;
      !(o_running && o_stopped);
   endproperty
   property p_start;
      s_cmd(5'h01) ##0 (i_meas_normal && !o_running && !o_stopped)
         |=> o_running && (o_no_data == o_ready);
   endproperty
   property p_stop;
      s_cmd(5'h02) ##0 (i_meas_normal && o_running) |=> o_stopped && !o_running;
   endproperty
   property p_rst;
      s_cmd(5'h04) ##0 (i_meas_normal && o_stopped) |=> !o_stopped && !o_running && o_no_data;
   endproperty
   // reset while running is refused, so running stays
   property p_refuse;
      s_cmd(5'h04) ##0 (o_running && !o_stopped) |=> o_running;
   endproperty
   property p_meas;
      s_req ##0 (i_wb_we && i_wb_adr == IRC_OFS_CMD && !i_meas_normal && o_stopped) |=> o_stopped;
   endproperty
   // display frozen for a while after hold rises
   property p_hold;
      $rose(o_hold) |=> $stable(o_disp_elapsed) [*4];
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_excl: assert property (p_excl) else $error("run and stop together");
   a_start: assert property (p_start) else $error("start ignored");
   a_stop: assert property (p_stop) else $error("stop ignored");
   a_rst: assert property (p_rst) else $error("reset ignored");
   a_refuse: assert property (p_refuse) else $error("reset taken in run");
   a_meas: assert property (p_meas) else $error("command taken off normal");
   a_hold: assert property (p_hold) else $error("display moved in hold");
endmodule
bind irc_top irc_chk irc_chk_i (.i_ref_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
   .i_wb_adr, .i_wb_dat, .o_wb_ack, .i_meas_normal, .o_running, .o_stopped, .o_hold,
   .o_no_data, .o_disp_elapsed, .o_ready);

// file: testbench/irc_keys.sv
// operator key panel model driving the key pins
module irc_keys (
   input  wire logic       i_clk,
   output      logic [4:0] o_keys
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_keys = 5'h00;
   // press one key n cycles; the released key is driven low, then 4 idle cycles
   task automatic press(input int b, input int n);
      o_keys[b] <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_keys[b] <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
endmodule

// file: testbench/tb_irc_top.sv
// self-checking bench for the integration run controller
module tb_irc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import irc_pkg::*;
   logic clk = 0, nrst = 0, req = 0, we = 0, meas = 1, tick = 0, svld = 0;
   logic [7:0]         adr = 8'h00;
   logic [31:0]        wdat = 32'h0, q, rd;
   logic signed [31:0] smp = 32'sh0, dval;
   logic [4:0]         keys;
   logic [25:0]        del;
   logic               ack, run, stp, rdy, hld, nod;
   irc_cal_t           cal = '0;
   int                 n_fail = 0, checks = 0;
   // command bits and status after each, mode 0, zero timer
   int         rc[9] = '{0, 3, 3, 1, 0, 2, 1, 1, 2};
   logic [5:0] rs[9] = '{6'h01, 6'h09, 6'h01, 6'h02, 6'h01, 6'h01, 6'h02, 6'h02, 6'h10};
   always #5 clk = ~clk;
   irc_top irc_top_i (.i_ref_clk(clk), .i_nrst(nrst), .i_wb_cyc(req), .i_wb_stb(req),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rd),
      .o_wb_ack(ack), .i_keys(keys), .i_meas_normal(meas), .i_sec_tick(tick), .i_cal(cal),
      .i_sample_vld(svld), .i_sample(smp), .o_running(run), .o_stopped(stp), .o_ready(rdy),
      .o_hold(hld), .o_no_data(nod), .o_disp_elapsed(del), .o_disp_value(dval));
   irc_keys irc_keys_i (.i_clk(clk), .o_keys(keys));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // one classic cycle, entered just after an edge; held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rd;
      if (ack !== 1'b1) chk(32'h0, 32'h1);
      req <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic cmd(input int b);
      wb(1'b1, IRC_OFS_CMD, 32'h1 << b);
   endtask
   // ports and status register agree with the expected state
   task automatic st(input logic [5:0] e);
      chk({27'h0, nod, hld, rdy, stp, run}, {27'h0, e[4:0]});
      wb(1'b0, IRC_OFS_STATUS, 32'h0);
      chk({26'h0, q[5:0]}, {26'h0, e});
   endtask
   // k second ticks, one idle cycle between
   task automatic tk(input int k);
      repeat (k) begin
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic pulse(input logic signed [31:0] v, input int k);
      smp <= v;
      svld <= 1'b1;
      repeat (k) @(posedge clk);
      svld <= 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      st(6'h10);
      rdc(IRC_OFS_CTRL, 32'h0);
      rdc(IRC_OFS_TIMER, 32'h0);
      rdc(8'h40, 32'h0); // unmapped
      wb(1'b1, IRC_OFS_CTRL, 32'h0);
      wb(1'b1, IRC_OFS_TIMER, 32'h0);
      for (int i = 0; i < 9; i++) begin
         cmd(rc[i]);
         st(rs[i]);
      end
      // accumulate, hold, single refresh
      cmd(IRC_CMD_START);
      tk(3);
      pulse(32'sd7, 2);
      irc_keys_i.press(IRC_CMD_HOLD, 2);
      tk(2);
      rdc(IRC_OFS_DISP_ELAP, 32'd3);
      rdc(IRC_OFS_ELAPSED, 32'd5);
      chk({6'h0, del}, 32'd3);
      irc_keys_i.press(IRC_CMD_SINGLE, 2);
      rdc(IRC_OFS_DISP_ELAP, 32'd5);
      chk({6'h0, del}, 32'd5);
      chk(dval, 32'd14);
      irc_keys_i.press(IRC_CMD_HOLD, 2);
      cmd(IRC_CMD_STOP);
      rdc(IRC_OFS_VALUE, 32'd14);
      cmd(IRC_CMD_START);
      tk(1);
      cmd(IRC_CMD_STOP);
      rdc(IRC_OFS_ELAPSED, 32'd6);
      meas <= 1'b0;
      cmd(IRC_CMD_START);
      st(6'h02);
      meas <= 1'b1;
      cmd(IRC_CMD_RESET);
      rdc(IRC_OFS_VALUE, 32'h0);
      // timer range, early stop then expiry
      wb(1'b1, IRC_OFS_TIMER, 32'h27100000);
      rdc(IRC_OFS_TIMER, 32'h27100000);
      wb(1'b1, IRC_OFS_TIMER, 32'h27100001);
      rdc(IRC_OFS_TIMER, 32'h27100000);
      wb(1'b1, IRC_OFS_TIMER, 32'h3);
      cmd(IRC_CMD_START);
      tk(1);
      cmd(IRC_CMD_STOP);
      cmd(IRC_CMD_START);
      tk(2);
      st(6'h02);
      rdc(IRC_OFS_ELAPSED, 32'd3);
      cmd(IRC_CMD_RESET);
      // repetitive restart
      wb(1'b1, IRC_OFS_CTRL, 32'h1);
      cmd(IRC_CMD_START);
      tk(4);
      st(6'h01);
      rdc(IRC_OFS_ELAPSED, 32'd1);
      cmd(IRC_CMD_STOP);
      cmd(IRC_CMD_RESET);
      // reserved single shot: wait for the start stamp, stop at the end stamp
      wb(1'b1, IRC_OFS_RS_TIME, 32'h2);
      wb(1'b1, IRC_OFS_RE_TIME, 32'h9);
      rdc(IRC_OFS_RE_TIME, 32'h9);
      wb(1'b1, IRC_OFS_CTRL, 32'h2);
      wb(1'b1, IRC_OFS_TIMER, 32'h0);
      cmd(IRC_CMD_START);
      tk(1);
      st(6'h15);
      cal.second <= 6'h2;
      tk(3);
      st(6'h01);
      cal.second <= 6'h9;
      tk(1);
      st(6'h02);
      rdc(IRC_OFS_ELAPSED, 32'd3);
      cmd(IRC_CMD_RESET);
      // reserved repetitive: restarts on expiry until the end stamp
      wb(1'b1, IRC_OFS_CTRL, 32'h3);
      wb(1'b1, IRC_OFS_TIMER, 32'h3);
      cal.second <= 6'h2;
      cmd(IRC_CMD_START);
      tk(5);
      st(6'h01);
      rdc(IRC_OFS_ELAPSED, 32'd1);
      cal.second <= 6'h9;
      tk(1);
      st(6'h02);
      cmd(IRC_CMD_RESET);
      // value limit stops the run
      wb(1'b1, IRC_OFS_CTRL, 32'h0);
      wb(1'b1, IRC_OFS_TIMER, 32'h0);
      cmd(IRC_CMD_START);
      pulse(32'sd999999, 1);
      repeat (3) @(posedge clk);
      rdc(IRC_OFS_VALUE, 32'h000f423f);
      st(6'h22);
      complete_run;
   end
endmodule
